// File: hdl/art_pkg.sv
// Package holding register map, field positions and reset values of the auto-reload PWM timer
package art_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_DUTY3 = 8'h73;
  localparam logic [7:0] IDX_DUTY2 = 8'h74;
  localparam logic [7:0] IDX_DUTY1 = 8'h75;
  localparam logic [7:0] IDX_DUTY0 = 8'h76;
  localparam logic [7:0] IDX_PWMCTL = 8'h77;
  localparam logic [7:0] IDX_CSR = 8'h78;
  localparam logic [7:0] IDX_CNT = 8'h79;
  localparam logic [7:0] IDX_RELOAD = 8'h7a;
  localparam logic [7:0] IDX_CAPCSR = 8'h7b;
  localparam logic [7:0] IDX_CAP1 = 8'h7c;
  localparam logic [7:0] IDX_CAP2 = 8'h7d;

  // ==========================================================================
  // Timer control/status fields
  localparam int CSR_CLKSRC = 7;
  localparam int CSR_PRESC_HI = 6;
  localparam int CSR_PRESC_LO = 4;
  localparam int CSR_RUN = 3;
  localparam int CSR_FORCE = 2;
  localparam int CSR_OVIE = 1;
  localparam int CSR_OVF = 0;

  // ==========================================================================
  // Capture control/status fields
  localparam int CAP_EDGE_LO = 4;
  localparam int CAP_IE_LO = 2;
  localparam int CAP_FLAG_LO = 0;

  // ==========================================================================
  // Reset values and widths
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hff;
  localparam int PRESC_W = 7;
  localparam logic [6:0] PRESC_ZERO = 7'h00;

endpackage

// File: hdl/pwm_autoreload_timer_regs.sv
// Auto-reload 8-bit PWM timer with four PWM outputs and two input captures, Wishbone slave
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps

// Functional notes
// - Run bit clear freezes prescaler and counter; set lets them count.
// - Force-reload bit reads zero; writing one loads reload value, clears prescaler.
// - Overflow interrupt enable gates the overflow interrupt request.
// - Overflow flag set on top-to-reload transition; cleared by reading control/status.
// - Counter access register reads live count and writes the counter anytime.
// - Overflow loads reload value and drives PWM outputs to the inverse of the polarity bit.
// - Four output enables independently connect each PWM channel to its pin.
// - Polarity zero: high at or below compare, low above; one inverts.
// - Changing a polarity bit inverts that output immediately.
// - Duty register sets second PWM edge; reload value sets the common first edge.
// - Top two capture control/status bits are reserved and read zero.
// - Capture edge select: zero falling edge, one rising edge.
// - Capture interrupt enables gate each capture channel's interrupt.
// - Capture sets channel flag; reading channel's capture register clears it.
// - Capture registers hold the counter value latched at the capture event.
// - Registers sit consecutively from duty ch3 through capture ch2.
// - Every register resets to zero.
// - Hidden compare registers load from duty registers only at overflow.
// - Prescale select picks one of eight taps: divide by two to the field.
// - Clock source select feeds prescaler from CPU clock or external input.
// - Capture register not updated again until software reads it.
module pwm_autoreload_timer_regs #(
  parameter int CHANNELS = 4,
  parameter int CAPTURES = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_clk_i,
  input wire logic [CAPTURES-1:0] capture_pin_i,
  output logic [CHANNELS-1:0] pwm_output_pin_o,
  output logic [CHANNELS-1:0] pwm_output_pin_oe_n_o,
  output logic overflow_irq_o,
  output logic [CAPTURES-1:0] capture_irq_o
);

  // ==========================================================================
  // Register storage
  logic [7:0] duty_cycle_q [CHANNELS];
  logic [7:0] compare_shadow_q [CHANNELS];
  logic [CHANNELS-1:0] output_enable_q;
  logic [CHANNELS-1:0] output_polarity_q;
  logic clock_source_select_q;
  logic [2:0] prescale_select_q;
  logic count_run_q;
  logic overflow_irq_enable_q;
  logic overflow_flag_q;
  logic [7:0] reload_value_q;
  logic [7:0] count_q;
  logic [6:0] presc_q;
  logic [CAPTURES-1:0] capture_edge_q;
  logic [CAPTURES-1:0] capture_irq_enable_q;
  logic [CAPTURES-1:0] capture_flag_q;
  logic [7:0] capture_value_q [CAPTURES];
  logic [CHANNELS-1:0] level_q;

  // ==========================================================================
  // Bus decode
  logic [7:0] idx;
  logic acc;
  logic wr;
  logic rd;
  logic lane0;
  assign idx = wb_adr_i[9:2];
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign lane0 = wb_sel_i[0];
  assign wr = acc && wb_we_i && lane0;
  assign rd = acc && !wb_we_i;

  // True when this cycle writes the given register index
  function automatic logic wr_to(input logic [7:0] target);
    return wr && (idx == target);
  endfunction

  // True when this cycle reads the given register index
  function automatic logic rd_of(input logic [7:0] target);
    return rd && (idx == target);
  endfunction

  // ==========================================================================
  // Input synchronisers for external clock and capture pins
  logic [1:0] ext_sync_q;
  logic ext_prev_q;
  logic [CAPTURES-1:0] cap_s1_q;
  logic [CAPTURES-1:0] cap_s2_q;
  logic [CAPTURES-1:0] cap_prev_q;

  // Two flops per pin, then a history flop for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_sync_q <= 2'h0;
      ext_prev_q <= 1'b0;
      cap_s1_q <= '0;
      cap_s2_q <= '0;
      cap_prev_q <= '0;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[0], ext_clk_i};
      ext_prev_q <= ext_sync_q[1];
      cap_s1_q <= capture_pin_i;
      cap_s2_q <= cap_s1_q;
      cap_prev_q <= cap_s2_q;
    end
  end

  // ==========================================================================
  // Prescaler input and tap selection
  logic input_tick;
  logic count_tick;
  logic [7:0] presc_next;
  logic force_load;
  logic cnt_write;
  logic overflow;
  assign input_tick = clock_source_select_q ? (ext_sync_q[1] && !ext_prev_q) : 1'b1;
  assign presc_next = {1'b0, presc_q} + 8'h01;
  // Tap n ticks when the low n prescaler bits wrap; tap zero every input tick
  assign count_tick = count_run_q && input_tick &&
    ((prescale_select_q == 3'h0) ||
     (presc_q & ((7'h01 << prescale_select_q) - 7'h01)) ==
     ((7'h01 << prescale_select_q) - 7'h01));
  assign force_load = wr_to(art_pkg::IDX_CSR) && wb_dat_i[art_pkg::CSR_FORCE];
  assign cnt_write = wr_to(art_pkg::IDX_CNT);
  assign overflow = count_tick && (count_q == art_pkg::COUNT_TOP) && !cnt_write && !force_load;

  // Prescaler: frozen when stopped, cleared by forced reload or counter write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      presc_q <= art_pkg::PRESC_ZERO;
    else if (force_load || cnt_write)
      presc_q <= art_pkg::PRESC_ZERO;
    else if (count_run_q && input_tick)
      presc_q <= presc_next[6:0];
  end

  // Counter: software write, forced reload, overflow reload or increment
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_q <= art_pkg::RESET_VAL;
    else if (cnt_write)
      count_q <= wb_dat_i[7:0];
    else if (force_load)
      count_q <= reload_value_q;
    else if (overflow)
      count_q <= reload_value_q;
    else if (count_tick)
      count_q <= count_q + 8'h01;
  end

  // ==========================================================================
  // Timer control/status register and overflow flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clock_source_select_q <= 1'b0;
      prescale_select_q <= 3'h0;
      count_run_q <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
    end
    else if (wr_to(art_pkg::IDX_CSR))
    begin
      clock_source_select_q <= wb_dat_i[art_pkg::CSR_CLKSRC];
      prescale_select_q <= wb_dat_i[art_pkg::CSR_PRESC_HI:art_pkg::CSR_PRESC_LO];
      count_run_q <= wb_dat_i[art_pkg::CSR_RUN];
      overflow_irq_enable_q <= wb_dat_i[art_pkg::CSR_OVIE];
    end
  end

  // Overflow flag: set wins over read-to-clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      overflow_flag_q <= 1'b0;
    else if (overflow)
      overflow_flag_q <= 1'b1;
    else if (rd_of(art_pkg::IDX_CSR))
      overflow_flag_q <= 1'b0;
  end

  // Overflow request gated by its enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      overflow_irq_o <= 1'b0;
    else
      overflow_irq_o <= overflow_flag_q && overflow_irq_enable_q;
  end

  // ==========================================================================
  // Reload value and PWM control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reload_value_q <= art_pkg::RESET_VAL;
      output_enable_q <= '0;
      output_polarity_q <= '0;
    end
    else
    begin
      if (wr_to(art_pkg::IDX_RELOAD))
        reload_value_q <= wb_dat_i[7:0];
      if (wr_to(art_pkg::IDX_PWMCTL))
      begin
        output_enable_q <= wb_dat_i[7:4];
        output_polarity_q <= wb_dat_i[3:0];
      end
    end
  end

  // ==========================================================================
  // Per-channel duty, shadow compare and PWM level
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_pwm
      // Duty register for channel ch sits at index duty0 minus ch
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          duty_cycle_q[ch] <= art_pkg::RESET_VAL;
        else if (wr_to(art_pkg::IDX_DUTY0 - 8'(ch)))
          duty_cycle_q[ch] <= wb_dat_i[7:0];
      end

      // Shadow compare loads only at overflow to avoid glitches
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          compare_shadow_q[ch] <= art_pkg::RESET_VAL;
        else if (overflow)
          compare_shadow_q[ch] <= duty_cycle_q[ch];
      end

      // Raw level: set at overflow, restored on the step that takes the counter past compare
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          level_q[ch] <= 1'b0;
        else if (overflow)
          level_q[ch] <= 1'b1;
        else if ((count_q > compare_shadow_q[ch]) ||
                 (count_tick && (count_q == compare_shadow_q[ch])))
          level_q[ch] <= 1'b0;
      end

      // Pin driven from polarity and level, released when disabled
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          pwm_output_pin_o[ch] <= 1'b0;
          pwm_output_pin_oe_n_o[ch] <= 1'b1;
        end
        else
        begin
          pwm_output_pin_o[ch] <= level_q[ch] ^ output_polarity_q[ch];
          pwm_output_pin_oe_n_o[ch] <= !output_enable_q[ch];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Capture channels
  logic [CAPTURES-1:0] cap_event;
  genvar cp;
  generate
    for (cp = 0; cp < CAPTURES; cp++)
    begin : g_cap
      assign cap_event[cp] = capture_edge_q[cp] ? (cap_s2_q[cp] && !cap_prev_q[cp])
                                                : (!cap_s2_q[cp] && cap_prev_q[cp]);

      // Latch counter on event, but only while flag is clear
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          capture_value_q[cp] <= art_pkg::RESET_VAL;
        else if (cap_event[cp] && !capture_flag_q[cp])
          capture_value_q[cp] <= count_q;
      end

      // Flag set by capture, cleared by reading the channel's capture register
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          capture_flag_q[cp] <= 1'b0;
        else if (cap_event[cp] && !capture_flag_q[cp])
          capture_flag_q[cp] <= 1'b1;
        else if (rd_of(art_pkg::IDX_CAP1 + 8'(cp)))
          capture_flag_q[cp] <= 1'b0;
      end

      // Capture request gated by its enable
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          capture_irq_o[cp] <= 1'b0;
        else
          capture_irq_o[cp] <= capture_flag_q[cp] && capture_irq_enable_q[cp];
      end
    end
  endgenerate

  // Capture control writes (flags are read-only)
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      capture_edge_q <= '0;
      capture_irq_enable_q <= '0;
    end
    else if (wr_to(art_pkg::IDX_CAPCSR))
    begin
      capture_edge_q <= wb_dat_i[5:4];
      capture_irq_enable_q <= wb_dat_i[3:2];
    end
  end

  // ==========================================================================
  // Read multiplexer
  logic [7:0] rdata;
  always_comb
  begin
    rdata = 8'h00;
    unique case (idx)
      art_pkg::IDX_DUTY3: rdata = duty_cycle_q[3];
      art_pkg::IDX_DUTY2: rdata = duty_cycle_q[2];
      art_pkg::IDX_DUTY1: rdata = duty_cycle_q[1];
      art_pkg::IDX_DUTY0: rdata = duty_cycle_q[0];
      art_pkg::IDX_PWMCTL: rdata = {output_enable_q, output_polarity_q};
      art_pkg::IDX_CSR: rdata = {clock_source_select_q, prescale_select_q, count_run_q,
                                 1'b0, overflow_irq_enable_q, overflow_flag_q};
      art_pkg::IDX_CNT: rdata = count_q;
      art_pkg::IDX_RELOAD: rdata = reload_value_q;
      art_pkg::IDX_CAPCSR: rdata = {2'h0, capture_edge_q, capture_irq_enable_q,
                                    capture_flag_q};
      art_pkg::IDX_CAP1: rdata = capture_value_q[0];
      art_pkg::IDX_CAP2: rdata = capture_value_q[1];
      default: rdata = 8'h00;
    endcase
  end

  // Single-wait-state acknowledge; unmapped addresses ack with zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= acc;
      wb_dat_o <= rd ? {24'h000000, rdata} : 32'h0000_0000;
    end
  end

endmodule

// File: tb/art_assertions.sv
// Concurrent checks on the timer's bus and pin ports
`timescale 1ns/100ps
module art_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [3:0] pwm_output_pin_oe_n_o,
  input wire logic overflow_irq_o,
  input wire logic [1:0] capture_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic [7:0] idx;
  logic [3:0] oe_exp_q;
  logic [2:0] csr_acc_q;
  logic [2:0] cap_acc_q;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = wb_adr_i[9:2];
  // Expected enables and recent accesses that may drop a request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      oe_exp_q <= 4'hf;
    else if (take && wb_we_i && wb_sel_i[0] && idx == art_pkg::IDX_PWMCTL)
      oe_exp_q <= ~wb_dat_i[7:4];
    csr_acc_q <= {csr_acc_q[1:0], take && idx == art_pkg::IDX_CSR};
    cap_acc_q <= {cap_acc_q[1:0], take && idx >= art_pkg::IDX_CAPCSR};
  end
  sequence wr_pwmctl;
    take && wb_we_i && wb_sel_i[0] && idx == art_pkg::IDX_PWMCTL;
  endsequence
  sequence rd_unmapped;
    take && !wb_we_i && (idx < art_pkg::IDX_DUTY3 || idx > art_pkg::IDX_CAP2);
  endsequence
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held beyond one cycle");
  chk_ack_latency: assert property (take |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_unmapped_zero: assert property (rd_unmapped |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_oe_follow: assert property (wr_pwmctl |=> ##[0:2] pwm_output_pin_oe_n_o == oe_exp_q)
    else $error("output enables do not follow control");
  chk_capcsr_resv: assert property (wb_ack_o && !wb_we_i && idx == art_pkg::IDX_CAPCSR
    |-> wb_dat_o[7:6] == 2'b00)
    else $error("reserved capture bits not zero");
  chk_force_zero: assert property (wb_ack_o && !wb_we_i && idx == art_pkg::IDX_CSR
    |-> !wb_dat_o[art_pkg::CSR_FORCE])
    else $error("force reload bit read as one");
  chk_ovf_drop: assert property ($fell(overflow_irq_o) |-> |csr_acc_q)
    else $error("overflow request dropped without access");
  chk_cap_drop: assert property ($fell(capture_irq_o[0]) || $fell(capture_irq_o[1])
    |-> |cap_acc_q)
    else $error("capture request dropped without access");
endmodule

// File: tb/pin_model.sv
// Far-side pin model: external count clock and capture inputs
`timescale 1ns/100ps
module pin_model (
  input wire logic clk_i,
  output logic ext_clk_o,
  output logic [1:0] capture_o
);
  initial
  begin
    ext_clk_o = 1'b0;
    capture_o = 2'b00;
  end
  // Slow count clock, nine system cycles per pulse, still between bursts
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_clk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  // New capture levels, then time to pass the synchronisers
  task automatic set_capture(input logic [1:0] v);
    @(posedge clk_i);
    capture_o <= v;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// File: tb/tb_pwm_autoreload_timer_regs.sv
// Self-checking testbench for the auto-reload PWM timer
`timescale 1ns/100ps
module tb_pwm_autoreload_timer_regs;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic ext_clk;
  logic [1:0] cap_pin;
  logic [3:0] pwm;
  logic [3:0] oe_n;
  logic ovf_irq;
  logic [1:0] cap_irq;
  logic [7:0] rd;
  logic [3:0] lv;
  int error_cnt = 0;
  int cmp_count = 0;
  int c;
  // ==========================================================================
  // Clock, design and pin model
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  pwm_autoreload_timer_regs DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_clk_i(ext_clk), .capture_pin_i(cap_pin),
    .pwm_output_pin_o(pwm), .pwm_output_pin_oe_n_o(oe_n), .overflow_irq_o(ovf_irq),
    .capture_irq_o(cap_irq));
  pin_model pins (.clk_i, .ext_clk_o(ext_clk), .capture_o(cap_pin));
  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One classic cycle; held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] sel = 4'h1);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    check("ack", 32'(n < 20), 32'h1);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(name, rd, exp);
  endtask
  task automatic count_high(input int ch);
    c = 0;
    repeat (256)
    begin
      @(posedge clk_i);
      c += (pwm[ch] === 1'b1);
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_map();
    for (int i = 0; i < 11; i++)
      rdc("reset reg", art_pkg::IDX_DUTY3 + 8'(i), 8'h00);
    check("oe_n reset", oe_n, 4'hf);
    rdc("unmapped", 8'h72, 8'h00);
    bus(1'b1, art_pkg::IDX_RELOAD, 8'h99, 4'he);
    rdc("sel ignored", art_pkg::IDX_RELOAD, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(art_pkg::IDX_DUTY3 + 8'(i), 8'h31 + 8'(i));
      rdc("rw reg", art_pkg::IDX_DUTY3 + 8'(i), 8'h31 + 8'(i));
    end
    wr(art_pkg::IDX_CAPCSR, 8'hff);
    rdc("capcsr", art_pkg::IDX_CAPCSR, 8'h3c);
    wr(art_pkg::IDX_CSR, 8'h76);
    rdc("csr", art_pkg::IDX_CSR, 8'h72);
  endtask
  task automatic t_ext();
    for (int n = 0; n < 3; n++)
    begin
      wr(art_pkg::IDX_CSR, {1'b1, 3'(n), 4'h8});
      wr(art_pkg::IDX_CNT, 8'h00);
      rdc("live write", art_pkg::IDX_CNT, 8'h00);
      pins.ext_pulses(8);
      wr(art_pkg::IDX_CSR, 8'h80);
      pins.ext_pulses(2);
      rdc("ext count", art_pkg::IDX_CNT, 8'(8 >> n));
    end
  endtask
  task automatic t_ovf();
    wr(art_pkg::IDX_RELOAD, 8'hf0);
    wr(art_pkg::IDX_CNT, 8'hfd);
    wr(art_pkg::IDX_CSR, 8'h0a);
    for (int i = 0; i < 50 && ovf_irq !== 1'b1; i++) @(posedge clk_i);
    check("ovf irq", ovf_irq, 1'b1);
    wr(art_pkg::IDX_CSR, 8'h02);
    rdc("ovf set", art_pkg::IDX_CSR, 8'h03);
    rdc("ovf clear", art_pkg::IDX_CSR, 8'h02);
    check("irq drop", ovf_irq, 1'b0);
    bus(1'b0, art_pkg::IDX_CNT, 8'h00);
    check("reloaded", 32'(rd >= 8'hf0), 32'h1);
    wr(art_pkg::IDX_CSR, 8'h08);
    repeat (40) @(posedge clk_i);
    check("irq masked", ovf_irq, 1'b0);
    wr(art_pkg::IDX_CSR, 8'h00);
    rdc("ovf masked", art_pkg::IDX_CSR, 8'h01);
    wr(art_pkg::IDX_RELOAD, 8'h55);
    wr(art_pkg::IDX_CSR, 8'h04);
    rdc("force", art_pkg::IDX_CNT, 8'h55);
  endtask
  task automatic t_pwm();
    wr(art_pkg::IDX_RELOAD, 8'h00);
    wr(art_pkg::IDX_DUTY0, 8'h80);
    wr(art_pkg::IDX_DUTY3, 8'h00);
    wr(art_pkg::IDX_PWMCTL, 8'h90);
    wr(art_pkg::IDX_CSR, 8'h08);
    check("oe_n", oe_n, 4'h6);
    repeat (300) @(posedge clk_i);
    count_high(0);
    check("duty 80", c, 129);
    count_high(3);
    check("duty 0", c, 1);
    wr(art_pkg::IDX_DUTY0, 8'h40);
    repeat (300) @(posedge clk_i);
    count_high(0);
    check("duty 40", c, 65);
    wr(art_pkg::IDX_PWMCTL, 8'h91);
    repeat (3) @(posedge clk_i);
    count_high(0);
    check("inverted", c, 191);
    wr(art_pkg::IDX_CSR, 8'h00);
    repeat (3) @(posedge clk_i);
    lv = pwm;
    wr(art_pkg::IDX_PWMCTL, 8'h90);
    repeat (3) @(posedge clk_i);
    check("flip", pwm, lv ^ 4'h1);
  endtask
  task automatic t_cap();
    wr(art_pkg::IDX_CNT, 8'h42);
    wr(art_pkg::IDX_CAPCSR, 8'h14);
    pins.set_capture(2'b01);
    check("cap irq", cap_irq, 2'b01);
    wr(art_pkg::IDX_CNT, 8'h43);
    pins.set_capture(2'b00);
    pins.set_capture(2'b01);
    rdc("cap held", art_pkg::IDX_CAP1, 8'h42);
    rdc("flag clear", art_pkg::IDX_CAPCSR, 8'h14);
    check("cap irq drop", cap_irq, 2'b00);
    wr(art_pkg::IDX_CAPCSR, 8'h00);
    pins.set_capture(2'b11);
    rdc("no rise", art_pkg::IDX_CAPCSR, 8'h00);
    pins.set_capture(2'b00);
    check("irq blocked", cap_irq, 2'b00);
    wr(art_pkg::IDX_CAPCSR, 8'h0c);
    @(posedge clk_i);
    check("irq both", cap_irq, 2'b11);
    rdc("fall flags", art_pkg::IDX_CAPCSR, 8'h0f);
    rdc("cap2", art_pkg::IDX_CAP2, 8'h43);
    rdc("cap1", art_pkg::IDX_CAP1, 8'h43);
    rdc("flags gone", art_pkg::IDX_CAPCSR, 8'h0c);
  endtask
  // Reset in mid-run while counting with enables set
  task automatic t_rst();
    wr(art_pkg::IDX_PWMCTL, 8'hff);
    wr(art_pkg::IDX_CSR, 8'h0a);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check("oe_n rst", oe_n, 4'hf);
    rdc("csr rst", art_pkg::IDX_CSR, 8'h00);
    rdc("pwmctl rst", art_pkg::IDX_PWMCTL, 8'h00);
    rdc("cnt rst", art_pkg::IDX_CNT, 8'h00);
    rdc("capcsr rst", art_pkg::IDX_CAPCSR, 8'h00);
  endtask
  // ==========================================================================
  // Verdict, main sequence and watchdog
  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_map();
    t_ext();
    t_ovf();
    t_pwm();
    t_cap();
    t_rst();
    complete_run();
  end
  initial
  begin
    #500000;
    error_cnt++;
    complete_run();
  end
endmodule
bind pwm_autoreload_timer_regs art_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pwm_output_pin_oe_n_o,
  .overflow_irq_o, .capture_irq_o);
